// ---- rtl/msit_pkg.sv ----
package msit_pkg;

  // default number of hardware interrupt sources
  localparam int NSRC_DEF = 8;

  // register port
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [4:0] REG_STATUS = 5'h00;
  localparam logic [4:0] REG_EVMASK = 5'h01;
  localparam logic [4:0] REG_REQ = 5'h02;
  localparam logic [4:0] REG_SRCMASK = 5'h03;
  localparam logic [4:0] REG_RAMIDX = 5'h04;
  localparam logic [4:0] REG_RAMDATA = 5'h05;
  localparam logic [4:0] REG_PATOUT = 5'h06;
  localparam logic [4:0] REG_VECREQ = 5'h07;
  localparam logic [1:0] REG_MSCTL_HI = 2'h1;
  localparam int MSCTL_SEL_W = 3;

  // status and event-mask bits
  localparam int NSTAT = 4;
  localparam int ST_ZERO = 0;
  localparam int ST_VEC = 1;
  localparam int ST_SUSP = 2;
  localparam int ST_SW = 3;

  // per-source channel control word
  localparam int CTL_EN = 0;
  localparam int CTL_CNT = 1;
  localparam int CTL_PTR_LO = 8;
  localparam int CTL_PTR_HI = 15;

  // ring word: pattern_step low byte, pattern_length high byte
  localparam int STEP_LO = 0;
  localparam int STEP_HI = 7;
  localparam int LEN_LO = 8;
  localparam int LEN_HI = 15;

  // channel memory: 16-bit words, byte pointer selects word
  localparam int RAM_DEPTH = 128;
  localparam int RAM_IW = 7;
  localparam logic [6:0] RING_OFS = 7'h01;
  localparam logic [6:0] BASE_OFS = 7'h02;

  // reset values
  localparam logic [15:0] MSCTL_RST = 16'h0000;
  localparam logic [7:0] SRCMASK_RST = 8'hFF;

  // timing in system clocks
  localparam int RESOLVE_CLKS = 8;
  localparam int DEFER_CLKS = 8;
  localparam int CNT_W = 4;

  // class of the instruction the sequencer is executing
  typedef enum logic [3:0] {
    IC_OTHER = 4'h0,
    IC_EIDI = 4'h1,
    IC_RETURN = 4'h2,
    IC_LDPSW = 4'h3,
    IC_WRICTL = 4'h4,
    IC_BITBR = 4'h5,
    IC_BLOCK = 4'h6
  } msit_iclass_e;

  // macro service engine
  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_RING = 2'b01,
    MS_COUNT = 2'b10
  } msit_ms_e;

endpackage

// ---- rtl/msit_seq_if.sv ----
`timescale 1ns/1ps
interface msit_seq_if;
  import msit_pkg::*;
  logic instrDone;
  msit_iclass_e instrClass;
  logic hold;

  modport defer (
    input instrDone,
    input instrClass,
    output hold
  );

  modport ctl (
    output instrDone,
    output instrClass,
    input hold
  );
endinterface

// ---- rtl/msit_defer.sv ----
`timescale 1ns/1ps
module msit_defer (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // sequencer side
  msit_seq_if.defer seq
);
  import msit_pkg::*;

  logic isDef;
  logic defDone;
  logic [CNT_W-1:0] holdCnt;
  logic needNext;

  // deferring classes; bit-test branches are not among them
  always_comb begin
    case (seq.instrClass)
      IC_EIDI, IC_RETURN, IC_LDPSW, IC_WRICTL: isDef = 1'b1;
      default: isDef = 1'b0;
    endcase
  end

  assign defDone = seq.instrDone && isDef;

  // eight-clock hold, re-armed on every deferring completion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      holdCnt <= '0;
    end else if (defDone) begin
      holdCnt <= CNT_W'(DEFER_CLKS);
    end else if (holdCnt != '0) begin
      holdCnt <= holdCnt - 1'b1;
    end
  end

  // the following instruction must also complete
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      needNext <= 1'b0;
    end else if (seq.instrDone) begin
      needNext <= isDef;
    end
  end

  assign seq.hold = defDone || (holdCnt != '0) || (needNext && !seq.instrDone);

endmodule

// ---- rtl/msit_top.sv ----
// Functional notes
// - ring control outputs one prepared pattern cycle in order, wrapping until the transfer count reaches zero
// - every macro-service transfer decrements the transfer count by one
// - ring control also raises a vectored request when the count reaches zero
// - counter mode only decrements the count; vectored request at zero
// - a counter-mode channel is just one 16-bit count word in memory
// - the channel pointer holds the low 8 address bits of the count
// - after a deferring instruction, acknowledge and macro service wait 8 clocks
// - software interrupts are never held by the deferral
// - deferring: EI/DI, returns, status/stack loads, interrupt control writes
// - a deferring instruction looping on itself keeps all hardware requests pending
// - block instructions suspend for an acknowledgeable request, then resume
// - a hardware event sets its request flag
// - priority resolution takes 8 clocks after a flag is set
// - acknowledge only when the executing instruction completes or while a block instruction executes
// - after a deferring instruction, acknowledge after the next one completes
// - pattern_step tracks the position within the pattern cycle
// - pattern_length gives the number of patterns in one cycle
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module msit_top #(
  parameter int NSRC = msit_pkg::NSRC_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [msit_pkg::ADDR_W-1:0] regAddr,
  input wire logic [msit_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [msit_pkg::DATA_W-1:0] regRdData,
  // interrupt sources
  input wire logic [NSRC-1:0] hwEvent,
  // instruction sequencer
  input wire logic instrDone,
  input wire msit_pkg::msit_iclass_e instrClass,
  input wire logic swIntReq,
  output logic intAck,
  output logic [$clog2(NSRC)-1:0] intVector,
  output logic swAck,
  output logic suspendReq,
  output logic msBusy,
  // pattern output and interrupt
  output logic [msit_pkg::DATA_W-1:0] patternOut,
  output logic irq
);
  import msit_pkg::*;

  localparam int VW = $clog2(NSRC);

  if (NSRC < 2 || NSRC > 8) begin : g_chk
    $error("NSRC must be between 2 and 8");
  end

  msit_seq_if seq ();

  assign seq.instrDone = instrDone;
  assign seq.instrClass = instrClass;

  msit_defer u_defer (
    .clk(clk),
    .arst_n(arst_n),
    .seq(seq)
  );

  // event pin synchronisers
  logic [NSRC-1:0] evS1;
  logic [NSRC-1:0] evS2;
  logic [NSRC-1:0] evS3;
  logic [NSRC-1:0] evLvl;
  logic [NSRC-1:0] evRise;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evS1 <= '0;
      evS2 <= '0;
      evS3 <= '0;
      evLvl <= '0;
    end else begin
      evS1 <= hwEvent;
      evS2 <= evS1;
      evS3 <= evS2;
      evLvl <= (evS2 & evS3) | (evLvl & ~(evS2 ^ evS3));
    end
  end

  assign evRise = evS2 & evS3 & ~evLvl;

  // state
  logic [NSTAT-1:0] status;
  logic [NSTAT-1:0] evMask;
  logic [NSRC-1:0] reqFlag;
  logic [NSRC-1:0] vecReq;
  logic [NSRC-1:0] srcMask;
  logic [DATA_W-1:0] msCtl [NSRC];
  logic [RAM_IW-1:0] ramIdx;
  logic [DATA_W-1:0] ram [RAM_DEPTH];
  logic [CNT_W-1:0] resolveCnt;
  msit_ms_e msState;
  logic [VW-1:0] msSrc;

  // register decode
  logic wrStatus;
  logic wrEvMask;
  logic wrReq;
  logic wrSrcMask;
  logic wrRamIdx;
  logic wrRamData;
  logic wrCtl;
  logic [MSCTL_SEL_W-1:0] ctlSel;

  assign ctlSel = regAddr[MSCTL_SEL_W-1:0];
  assign wrStatus = regWr && (regAddr == REG_STATUS);
  assign wrEvMask = regWr && (regAddr == REG_EVMASK);
  assign wrReq = regWr && (regAddr == REG_REQ);
  assign wrSrcMask = regWr && (regAddr == REG_SRCMASK);
  assign wrRamIdx = regWr && (regAddr == REG_RAMIDX);
  assign wrRamData = regWr && (regAddr == REG_RAMDATA);
  assign wrCtl = regWr && (regAddr[ADDR_W-1:MSCTL_SEL_W] == REG_MSCTL_HI)
    && (int'(ctlSel) < NSRC);

  // priority selection, lowest index first
  logic [NSRC-1:0] pend;
  logic [VW-1:0] selIdx;
  logic selVec;
  logic resolved;
  logic ackPoint;
  logic take;
  logic swTake;

  assign pend = (reqFlag | vecReq) & ~srcMask;

  always_comb begin
    selIdx = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        selIdx = VW'(i);
      end
    end
  end

  assign selVec = vecReq[selIdx] || !msCtl[selIdx][CTL_EN];
  assign resolved = (resolveCnt == '0);
  assign ackPoint = instrDone || (instrClass == IC_BLOCK);
  assign swTake = swIntReq && instrDone;
  assign take = (|pend) && resolved && !seq.hold && ackPoint
    && (msState == MS_IDLE) && !swTake;

  // channel addressing
  logic [RAM_IW-1:0] cntIdx;
  logic [RAM_IW-1:0] ringIdx;
  logic [RAM_IW-1:0] baseIdx;
  logic [RAM_IW-1:0] patIdx;
  logic [7:0] step;
  logic [7:0] len;
  logic [7:0] nextStep;
  logic [DATA_W-1:0] count;
  logic [DATA_W-1:0] nextCount;
  logic countZero;
  logic [NSRC-1:0] vecSet;

  assign cntIdx = msCtl[msSrc][CTL_PTR_HI:CTL_PTR_LO+1];
  assign ringIdx = cntIdx + RING_OFS;
  assign baseIdx = cntIdx + BASE_OFS;
  assign step = ram[ringIdx][STEP_HI:STEP_LO];
  assign len = ram[ringIdx][LEN_HI:LEN_LO];
  assign patIdx = ram[baseIdx][RAM_IW-1:0] + RAM_IW'(len - step);
  assign nextStep = (step == 8'h01 || step == 8'h00) ? len : step - 8'h01;
  assign count = ram[cntIdx];
  assign nextCount = count - 16'h0001;
  assign countZero = (msState == MS_COUNT) && (nextCount == 16'h0000);

  always_comb begin
    vecSet = '0;
    if (countZero) begin
      vecSet[msSrc] = 1'b1;
    end
  end

  // priority resolution window restarts on every new flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resolveCnt <= '0;
    end else if ((|(evRise & ~reqFlag)) || (|vecSet)) begin
      resolveCnt <= CNT_W'(RESOLVE_CLKS);
    end else if (resolveCnt != '0) begin
      resolveCnt <= resolveCnt - 1'b1;
    end
  end

  // request flags; a set wins over a clear
  logic [NSRC-1:0] ackClr;

  always_comb begin
    ackClr = '0;
    if (take) begin
      ackClr[selIdx] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reqFlag <= '0;
    end else begin
      reqFlag <= (reqFlag & ~ackClr & ~(wrReq ? regWrData[NSRC-1:0] : '0)) | evRise;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vecReq <= '0;
    end else begin
      vecReq <= (vecReq & ~(selVec ? ackClr : '0)) | vecSet;
    end
  end

  // macro service engine
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      msState <= MS_IDLE;
      msSrc <= '0;
    end else begin
      case (msState)
        MS_IDLE: begin
          if (take && !selVec) begin
            msSrc <= selIdx;
            msState <= msCtl[selIdx][CTL_CNT] ? MS_COUNT : MS_RING;
          end
        end
        MS_RING: msState <= MS_COUNT;
        MS_COUNT: msState <= MS_IDLE;
        default: msState <= MS_IDLE;
      endcase
    end
  end

  // channel memory: engine write first, then software
  always_ff @(posedge clk) begin
    if (msState == MS_RING) begin
      ram[ringIdx][STEP_HI:STEP_LO] <= nextStep;
    end else if (msState == MS_COUNT) begin
      ram[cntIdx] <= nextCount;
    end else if (wrRamData) begin
      ram[ramIdx] <= regWrData;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      patternOut <= '0;
    end else if (msState == MS_RING) begin
      patternOut <= ram[patIdx];
    end
  end

  // channel control words; a zero count hands the source to vectored service
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NSRC; i++) begin
        msCtl[i] <= MSCTL_RST;
      end
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (wrCtl && int'(ctlSel) == i) begin
          msCtl[i] <= regWrData;
        end
        if (vecSet[i]) begin
          msCtl[i][CTL_EN] <= 1'b0;
        end
      end
    end
  end

  // plain control registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evMask <= '0;
      srcMask <= SRCMASK_RST[NSRC-1:0];
      ramIdx <= '0;
    end else begin
      if (wrEvMask) begin
        evMask <= regWrData[NSTAT-1:0];
      end
      if (wrSrcMask) begin
        srcMask <= regWrData[NSRC-1:0];
      end
      if (wrRamIdx) begin
        ramIdx <= regWrData[RAM_IW-1:0];
      end
    end
  end

  // sequencer outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      intAck <= 1'b0;
      intVector <= '0;
      swAck <= 1'b0;
      suspendReq <= 1'b0;
      msBusy <= 1'b0;
    end else begin
      intAck <= take && selVec;
      if (take) begin
        intVector <= selIdx;
      end
      swAck <= swTake;
      suspendReq <= take && (instrClass == IC_BLOCK) && !instrDone;
      msBusy <= (take && !selVec) || (msState == MS_RING);
    end
  end

  // event status, write one to clear, set wins
  logic [NSTAT-1:0] stEvent;

  always_comb begin
    stEvent = '0;
    stEvent[ST_ZERO] = countZero;
    stEvent[ST_VEC] = take && selVec;
    stEvent[ST_SUSP] = take && (instrClass == IC_BLOCK) && !instrDone;
    stEvent[ST_SW] = swTake;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~(wrStatus ? regWrData[NSTAT-1:0] : '0)) | stEvent;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & evMask);
    end
  end

  // read data, one cycle after the strobe
  logic [DATA_W-1:0] rdMux;

  always_comb begin
    rdMux = '0;
    case (regAddr)
      REG_STATUS: rdMux[NSTAT-1:0] = status;
      REG_EVMASK: rdMux[NSTAT-1:0] = evMask;
      REG_REQ: rdMux[NSRC-1:0] = reqFlag;
      REG_SRCMASK: rdMux[NSRC-1:0] = srcMask;
      REG_RAMIDX: rdMux[RAM_IW-1:0] = ramIdx;
      REG_RAMDATA: rdMux = ram[ramIdx];
      REG_PATOUT: rdMux = patternOut;
      REG_VECREQ: rdMux[NSRC-1:0] = vecReq;
      default: begin
        if (regAddr[ADDR_W-1:MSCTL_SEL_W] == REG_MSCTL_HI && int'(ctlSel) < NSRC) begin
          rdMux = msCtl[ctlSel];
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= '0;
    end else begin
      regRdData <= regRd ? rdMux : '0;
    end
  end

endmodule

// ---- sim/msit_top_sva.sv ----
`timescale 1ns/1ps
module msit_top_chk #(
  parameter int NSRC = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // sources and sequencer
  input wire logic [NSRC-1:0] hwEvent,
  input wire logic instrDone,
  input wire msit_pkg::msit_iclass_e instrClass,
  input wire logic swIntReq,
  // takes
  input wire logic intAck,
  input wire logic swAck,
  input wire logic suspendReq,
  input wire logic msBusy
);
  import msit_pkg::*;
  logic holdFlag;
  logic isDefer;
  logic holdNow;
  assign isDefer = instrClass inside {IC_EIDI, IC_RETURN, IC_LDPSW, IC_WRICTL};
  assign holdNow = (holdFlag || (instrDone && isDefer)) && !(instrDone && !isDefer);
  // remembers a deferring end until a plain instruction ends
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      holdFlag <= 1'b0;
    end else if (instrDone) begin
      holdFlag <= isDefer;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_quiet;
    !intAck && !$rose(msBusy) && !suspendReq;
  endsequence
  sequence s_take;
    intAck || $rose(msBusy);
  endsequence
  property p_defer8;
    instrDone && isDefer |=> s_quiet [*8];
  endproperty
  a_defer8: assert property (p_defer8) else $error("take in deferral window");
  property p_hold;
    s_take |-> !$past(holdNow);
  endproperty
  a_hold: assert property (p_hold) else $error("take while held");
  property p_ack_done;
    intAck |-> $past(instrDone || instrClass == IC_BLOCK);
  endproperty
  a_ack_done: assert property (p_ack_done) else $error("ack mid instruction");
  property p_sw_take;
    swIntReq && instrDone |=> swAck;
  endproperty
  a_sw_take: assert property (p_sw_take) else $error("sw request not taken");
  property p_sw_cause;
    swAck |-> $past(swIntReq && instrDone);
  endproperty
  a_sw_cause: assert property (p_sw_cause) else $error("sw ack without cause");
  // three sync flops, then the full eight-clock resolve window stays quiet
  property p_resolve;
    |(hwEvent & ~$past(hwEvent)) |-> ##4 s_quiet [*8];
  endproperty
  a_resolve: assert property (p_resolve) else $error("take during resolve");
  property p_ack_pulse;
    intAck |=> !intAck;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_busy_len;
    msBusy [*2] |=> !msBusy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("service too long");
  property p_susp;
    suspendReq |-> $past(instrClass == IC_BLOCK);
  endproperty
  a_susp: assert property (p_susp) else $error("suspend of wrong class");
endmodule

bind msit_top msit_top_chk #(.NSRC(NSRC)) i_chk (.clk(clk), .arst_n(arst_n),
  .hwEvent(hwEvent), .instrDone(instrDone), .instrClass(instrClass),
  .swIntReq(swIntReq), .intAck(intAck), .swAck(swAck), .suspendReq(suspendReq),
  .msBusy(msBusy));

// ---- sim/msit_seq_model.sv ----
`timescale 1ns/1ps
module msit_seq_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bench control
  input wire logic run,
  input wire logic slow,
  input wire msit_pkg::msit_iclass_e nextClass,
  // sequencer
  output logic instrDone,
  output msit_pkg::msit_iclass_e instrClass
);
  import msit_pkg::*;
  logic [1:0] cnt;
  // one instruction every 2 or 5 clocks; class loads as the previous one ends
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 2'h0;
      instrDone <= 1'b0;
      instrClass <= IC_OTHER;
    end else begin
      cnt <= instrDone ? 2'h0 : cnt + 2'h1;
      instrDone <= run && !instrDone && (cnt == (slow ? 2'h3 : 2'h0));
      if (!run || instrDone) begin
        instrClass <= nextClass;
      end
    end
  end
endmodule

// ---- sim/msit_top_tb.sv ----
`timescale 1ns/1ps
module msit_top_tb;
  import msit_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdData;
  logic [7:0] hwEvent = 8'h00;
  logic instrDone;
  msit_iclass_e instrClass;
  msit_iclass_e nextClass = IC_OTHER;
  logic run = 1'b0;
  logic slow = 1'b0;
  logic swIntReq = 1'b0;
  logic intAck;
  logic [2:0] intVector;
  logic swAck;
  logic suspendReq;
  logic msBusy;
  logic [15:0] patternOut;
  logic irq;
  logic [3:0] sig;
  logic [15:0] d;
  logic [3:0] seen;
  int error_cnt = 0;
  int tests_run = 0;
  int n;
  assign sig = {suspendReq, instrDone, msBusy, intAck};

  always #12.5 clk = ~clk;

  msit_top #(.NSRC(8)) i_dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .hwEvent(hwEvent), .instrDone(instrDone), .instrClass(instrClass),
    .swIntReq(swIntReq), .intAck(intAck), .intVector(intVector), .swAck(swAck),
    .suspendReq(suspendReq), .msBusy(msBusy), .patternOut(patternOut), .irq(irq));
  msit_seq_model i_seq (.clk(clk), .arst_n(arst_n), .run(run), .slow(slow),
    .nextClass(nextClass), .instrDone(instrDone), .instrClass(instrClass));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask

  task automatic ramWr(input logic [6:0] i, input logic [15:0] v);
    wr(REG_RAMIDX, {9'h000, i});
    wr(REG_RAMDATA, v);
  endtask

  // sel: 0 ack, 1 busy, 2 done, 3 suspend; sampled mid-cycle, returns on the next rising edge
  task automatic waitFor(input int sel);
    n = 0;
    do begin
      @(negedge clk);
      n++;
      seen = sig;
    end while (sig[sel] !== 1'b1 && n < 300);
    @(posedge clk);
    if (n >= 300) begin
      error_cnt++;
      $display("[ERR] %0t wait timed out", $time);
      end_sim();
    end
  endtask

  task automatic ev(input int i);
    @(posedge clk);
    hwEvent[i] <= 1'b1;
    waitFor(1);
    hwEvent[i] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic t_reset();
    rd(REG_SRCMASK);
    chk(d, {8'h00, SRCMASK_RST});
    chk({11'h000, intAck, swAck, suspendReq, msBusy, irq}, 16'h0000);
    chk(patternOut, 16'h0000);
    rd(REG_STATUS);
    chk(d, 16'h0000);
    rd(5'h1F);
    chk(d, 16'h0000);
    wr(REG_SRCMASK, 16'h0000);
    wr(REG_EVMASK, 16'h000F);
    $display("reset test end");
  endtask

  task automatic t_vec();
    run <= 1'b1;
    @(posedge clk);
    hwEvent[0] <= 1'b1;
    repeat (4) @(posedge clk);
    rd(REG_REQ);
    chk(d & 16'h0001, 16'h0001);
    waitFor(0);
    chk(16'(n + 2 > RESOLVE_CLKS), 16'h0001);
    chk({13'h0000, intVector}, 16'h0000);
    hwEvent[0] <= 1'b0;
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0001);
    wr(REG_STATUS, 16'h000F);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    $display("vectored test end");
  endtask

  task automatic t_sw();
    nextClass <= IC_RETURN;
    swIntReq <= 1'b1;
    waitFor(2);
    waitFor(2);
    @(negedge clk);
    chk({15'h0000, swAck}, 16'h0001);
    @(posedge clk);
    swIntReq <= 1'b0;
    nextClass <= IC_OTHER;
    repeat (12) @(posedge clk);
    $display("software test end");
  endtask

  task automatic t_defer();
    run <= 1'b0;
    slow <= 1'b1;
    nextClass <= IC_EIDI;
    hwEvent[1] <= 1'b1;
    repeat (16) @(posedge clk);
    // the deferring class stays loaded until its own completion
    run <= 1'b1;
    nextClass <= IC_OTHER;
    waitFor(2);
    waitFor(0);
    chk(16'(n > DEFER_CLKS), 16'h0001);
    chk({13'h0000, intVector}, 16'h0001);
    hwEvent[1] <= 1'b0;
    slow <= 1'b0;
    $display("deferral test end");
  endtask

  task automatic t_count();
    ramWr(7'h10, 16'h0002);
    wr(5'h0A, 16'h2003);
    ev(2);
    rd(REG_RAMDATA);
    chk(d, 16'h0001);
    ev(2);
    waitFor(0);
    chk({13'h0000, intVector}, 16'h0002);
    rd(REG_STATUS);
    chk(d & 16'h0001, 16'h0001);
    rd(REG_RAMDATA);
    chk(d, 16'h0000);
    $display("counter test end");
  endtask

  task automatic t_ring();
    ramWr(7'h20, 16'h0003);
    ramWr(7'h21, 16'h0202);
    ramWr(7'h22, 16'h0050);
    ramWr(7'h50, 16'hA5A1);
    ramWr(7'h51, 16'h5A52);
    wr(5'h0B, 16'h4001);
    for (int k = 0; k < 3; k++) begin
      ev(3);
      chk(patternOut, (k == 1) ? 16'h5A52 : 16'hA5A1);
    end
    waitFor(0);
    chk({13'h0000, intVector}, 16'h0003);
    wr(REG_RAMIDX, 16'h0021);
    rd(REG_RAMDATA);
    chk(d, 16'h0201);
    $display("ring test end");
  endtask

  task automatic t_block();
    @(posedge clk);
    run <= 1'b0;
    nextClass <= IC_BLOCK;
    repeat (2) @(posedge clk);
    hwEvent[4] <= 1'b1;
    waitFor(3);
    // suspend and vectored ack together, no done, no macro service
    chk({12'h000, seen}, 16'h0009);
    chk({13'h0000, intVector}, 16'h0004);
    hwEvent[4] <= 1'b0;
    $display("suspend test end");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_vec();
    t_sw();
    t_defer();
    t_count();
    t_ring();
    t_block();
    end_sim();
  end
endmodule
